/* File: design/carl_pkg.sv */
// Constants for the command/address reference level mode register.
package carl_pkg;

	// Mode register address decoded by this block.
	localparam logic [5:0] CARL_MODE_ADDR = 6'h0c;

	// Field layout of the 8-bit register.
	localparam int CARL_CODE_LSB = 0;
	localparam int CARL_CODE_W = 6;
	localparam int CARL_RANGE_BIT = 6;
	localparam int CARL_RSVD_BIT = 7;
	localparam int CARL_WORD_W = 7;

	// Highest level code that is valid in either range.
	localparam logic [5:0] CARL_CODE_MAX = 6'h32;

	// Reset value of one set-point copy: range 1, level code 011101.
	localparam logic [0:0] CARL_RANGE_RST = 1'h1;
	localparam logic [5:0] CARL_CODE_RST = 6'h1d;
	localparam logic [6:0] CARL_WORD_RST = {CARL_RANGE_RST, CARL_CODE_RST};

	// Number of frequency set points, one physical copy each.
	localparam int CARL_SETPOINTS = 2;

endpackage

/* File: design/carl_copy.sv */
// One set-point copy of the reference level register.
module carl_copy #(
	parameter int WORD_W = carl_pkg::CARL_WORD_W
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic wr_en_i,
	input wire logic [WORD_W-1:0] wr_data_i,
	output logic [WORD_W-1:0] word_o
);

	logic [WORD_W-1:0] next_word;

	if (WORD_W != carl_pkg::CARL_WORD_W) begin : g_width_check
		$error("carl_copy: WORD_W must equal the register field width");
	end

	// Outside reset, the copy only changes on a targeted write; otherwise it holds.
	always_comb begin
		next_word = word_o;
		if (wr_en_i) begin
			next_word = wr_data_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			word_o <= carl_pkg::CARL_WORD_RST;
		end else begin
			word_o <= next_word;
		end
	end

endmodule

/* File: design/carl_reg.sv */
// Command/address reference level mode register with two set-point copies.

// Operation
// - Register answers mode register write and read at address 0C hex.
// - Bits 5..0 level code, bit 6 range select, bit 7 reserved.
// - Level codes above 110010 are reserved; controller must not program them.
// - Reset gives range select 1 with level code 011101.
// - Two copies; writes and reads reach only the write-selected copy.
// - Device runs only from operate-selected copy; inactive writes change nothing.
// - Read drives register bits 7..0 on DQ 7..0, reserved bits zero.
// - Written value holds until rewritten or reset.
// - Write-select bit 0 picks set point 0, 1 picks set point 1.
// - Operate-select bit 0 runs set point 0, 1 runs set point 1.
module carl_reg (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic mrw_valid_i,
	input wire logic mrr_valid_i,
	input wire logic [5:0] mode_addr_i,
	input wire logic [7:0] mode_op_i,
	input wire logic setpoint_write_select_i,
	input wire logic setpoint_operate_select_i,
	output logic [7:0] dq_o,
	output logic dq_oe_o,
	output logic mrr_data_valid_o,
	output logic [5:0] ca_ref_level_code_o,
	output logic ca_ref_range_select_o,
	output logic ca_ref_code_reserved_o
);

	localparam int NSP = carl_pkg::CARL_SETPOINTS;
	localparam int WW = carl_pkg::CARL_WORD_W;

	logic mrw_hit;
	logic mrr_hit;
	logic [WW-1:0] copy_word [NSP];
	logic [WW-1:0] wsel_word;
	logic [WW-1:0] osel_word;
	logic [7:0] next_dq;
	logic next_dq_oe;
	logic next_mrr_valid;
	logic [5:0] next_code;
	logic next_range;
	logic next_reserved;

	// Both commands must carry this register's address to touch it.
	assign mrw_hit = mrw_valid_i && (mode_addr_i == carl_pkg::CARL_MODE_ADDR);
	assign mrr_hit = mrr_valid_i && (mode_addr_i == carl_pkg::CARL_MODE_ADDR);

	// Bit 7 of the write data is reserved and is never stored. The range
	// bit is taken from the same write as the code, so a write always sets
	// both fields together.
	for (genvar sp = 0; sp < NSP; sp++) begin : g_copy
		carl_copy #(
			.WORD_W(WW)
		) u_copy (
			.core_clk_i(core_clk_i),
			.rst_i(rst_i),
			// The cast keeps the set-point compare one bit wide on both sides.
			.wr_en_i(mrw_hit && (setpoint_write_select_i == 1'(sp))),
			.wr_data_i(mode_op_i[WW-1:0]),
			.word_o(copy_word[sp])
		);
	end

	assign wsel_word = copy_word[setpoint_write_select_i];
	assign osel_word = copy_word[setpoint_operate_select_i];

	// A reserved code is not rejected: it is stored as written, and only
	// flagged, because the device has no way to refuse a mode write.
	function automatic logic code_reserved(input logic [5:0] code);
		code_reserved = code > carl_pkg::CARL_CODE_MAX;
	endfunction

	always_comb begin
		next_dq = 8'h00;
		next_dq_oe = 1'b0;
		next_mrr_valid = 1'b0;
		if (mrr_hit) begin
			next_dq = {1'b0, wsel_word};
			next_dq_oe = 1'b1;
			next_mrr_valid = 1'b1;
		end
		next_code = osel_word[carl_pkg::CARL_CODE_W-1:0];
		next_range = osel_word[carl_pkg::CARL_RANGE_BIT];
		next_reserved = code_reserved(osel_word[5:0]);
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			dq_o <= 8'h00;
			dq_oe_o <= 1'b0;
			mrr_data_valid_o <= 1'b0;
			ca_ref_level_code_o <= carl_pkg::CARL_CODE_RST;
			ca_ref_range_select_o <= carl_pkg::CARL_RANGE_RST;
			ca_ref_code_reserved_o <= 1'b0;
		end else begin
			dq_o <= next_dq;
			dq_oe_o <= next_dq_oe;
			mrr_data_valid_o <= next_mrr_valid;
			ca_ref_level_code_o <= next_code;
			ca_ref_range_select_o <= next_range;
			ca_ref_code_reserved_o <= next_reserved;
		end
	end

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	// The reset term is judged on its current value, so at the edge that
	// releases reset an attempt is already live while the copies still show
	// their pre-reset contents. Each default-disabled property that looks across an edge, except
	// a_foreign_addr_quiet, a_inactive_no_effect and a_idle_bus_quiet,
	// therefore also asks for a sampled low reset at its start.

	sequence s_write_inactive;
		mrw_hit && (setpoint_write_select_i != setpoint_operate_select_i);
	endsequence

	sequence s_operate_held;
		$stable(setpoint_operate_select_i);
	endsequence

	// A write that lands in the copy the device is running from.
	sequence s_write_active;
		!rst_i && mrw_hit &&
			(setpoint_write_select_i == setpoint_operate_select_i);
	endsequence

	a_read_returns_copy: assert property (
		(!rst_i && mrr_hit) |=> dq_oe_o && mrr_data_valid_o &&
			(dq_o == {1'b0, $past(wsel_word)})
	) else $error("read data does not match write-selected copy");

	a_reserved_bit_zero: assert property (
		dq_o[carl_pkg::CARL_RSVD_BIT] == 1'b0
	) else $error("reserved bit driven high on read");

	a_foreign_addr_quiet: assert property (
		(mrr_valid_i && !mrr_hit) |=> !dq_oe_o && (dq_o == 8'h00)
	) else $error("read of another address answered");

	a_write_sp0_only: assert property (
		(!rst_i && mrw_hit && !setpoint_write_select_i) |=>
			(copy_word[0] == $past(mode_op_i[6:0])) && $stable(copy_word[1])
	) else $error("write to set point 0 misrouted");

	a_write_sp1_only: assert property (
		(!rst_i && mrw_hit && setpoint_write_select_i) |=>
			(copy_word[1] == $past(mode_op_i[6:0])) && $stable(copy_word[0])
	) else $error("write to set point 1 misrouted");

	a_value_persists: assert property (
		(!rst_i && !mrw_hit) |=> $stable(copy_word[0]) &&
			$stable(copy_word[1])
	) else $error("copy changed without a write");

	a_reset_defaults: assert property (disable iff (1'b0)
		rst_i |=> (copy_word[0] == carl_pkg::CARL_WORD_RST) &&
			(copy_word[1] == carl_pkg::CARL_WORD_RST) &&
			ca_ref_range_select_o && (ca_ref_level_code_o == carl_pkg::CARL_CODE_RST)
	) else $error("reset value wrong");

	a_operate_follows: assert property (
		!rst_i |=> {ca_ref_range_select_o, ca_ref_level_code_o} ==
			$past(osel_word)
	) else $error("operating value not from operate-selected copy");

	a_inactive_no_effect: assert property (
		(s_write_inactive ##1 s_operate_held) |=>
			$stable(ca_ref_level_code_o) && $stable(ca_ref_range_select_o)
	) else $error("write to inactive copy changed operation");

	a_reserved_flag: assert property (
		ca_ref_code_reserved_o == (ca_ref_level_code_o > carl_pkg::CARL_CODE_MAX)
	) else $error("reserved code flag wrong");

	// A write to the running copy reaches the operating outputs two edges
	// after the command, provided the operate select holds still.
	a_active_write_lands: assert property (
		(s_write_active ##1 s_operate_held) |=>
			({ca_ref_range_select_o, ca_ref_level_code_o} ==
			$past(mode_op_i[6:0], 2))
	) else $error("write to running copy did not reach operation");

	a_active_reserved_flag: assert property (
		(s_write_active ##1 s_operate_held) |=>
			(ca_ref_code_reserved_o ==
			($past(mode_op_i[5:0], 2) > carl_pkg::CARL_CODE_MAX))
	) else $error("reserved flag wrong after write to running copy");

	// A reserved code is kept exactly as written in the targeted copy.
	a_reserved_write_kept: assert property (
		(!rst_i && mrw_hit && (mode_op_i[5:0] > carl_pkg::CARL_CODE_MAX))
			|=> ($past(mode_op_i[5:0]) ==
			($past(setpoint_write_select_i) ?
			copy_word[1][5:0] : copy_word[0][5:0]))
	) else $error("reserved code not stored as written");

	// A read must not disturb either copy.
	a_read_keeps_copies: assert property (
		(!rst_i && mrr_hit && !mrw_hit) |=> $stable(copy_word[0]) &&
			$stable(copy_word[1])
	) else $error("read changed a stored copy");

	// Outside the cycle after a read the data lines carry zero.
	a_idle_bus_quiet: assert property (
		!mrr_hit |=> !dq_oe_o && !mrr_data_valid_o && (dq_o == 8'h00)
	) else $error("read outputs active without a read");

	// The enable and the valid pulse are one event seen by two users.
	a_oe_valid_pair: assert property (
		dq_oe_o == mrr_data_valid_o
	) else $error("output enable and read valid disagree");

	a_reset_bus_idle: assert property (disable iff (1'b0)
		rst_i |=> !dq_oe_o && !mrr_data_valid_o && (dq_o == 8'h00) &&
			!ca_ref_code_reserved_o
	) else $error("read outputs or flag active after reset");

	// A switch of the operate select alone moves the outputs to the other
	// copy one edge later.
	a_operate_switch: assert property (
		(!rst_i && $changed(setpoint_operate_select_i)) |=>
			(ca_ref_level_code_o == $past(osel_word[5:0]))
	) else $error("operate select change not followed");

endmodule

/* File: tb/carl_ctrl_model.sv */
// Memory controller model issuing mode register writes and reads.
module carl_ctrl_model (
	input wire logic core_clk_i,
	input wire logic [7:0] dq_i,
	input wire logic dq_oe_i,
	input wire logic mrr_data_valid_i,
	output logic mrw_valid_o,
	output logic mrr_valid_o,
	output logic [5:0] mode_addr_o,
	output logic [7:0] mode_op_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		mrw_valid_o = 1'h0;
		mrr_valid_o = 1'h0;
		mode_addr_o = 6'h00;
		mode_op_o = 8'h00;
	end
	// Range and code always leave together in one operand.
	task automatic mrw(input logic [5:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		mrw_valid_o <= 1'h1;
		mode_addr_o <= a;
		mode_op_o <= d;
		@(posedge core_clk_i);
		mrw_valid_o <= 1'h0;
		// Released lines flip so a stale value can never pass as valid.
		mode_addr_o <= ~a;
		mode_op_o <= ~d;
	endtask
	task automatic mrr(input logic [5:0] a, output logic [9:0] r);
		@(posedge core_clk_i);
		mrr_valid_o <= 1'h1;
		mode_addr_o <= a;
		@(posedge core_clk_i);
		mrr_valid_o <= 1'h0;
		mode_addr_o <= ~a;
		#1;
		r = {dq_oe_i, mrr_data_valid_i, dq_i};
	endtask
endmodule

/* File: tb/test_carl_reg.sv */
// Self-checking bench for the reference level mode register.
module test_carl_reg;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 1'h0;
	logic rst = 1'h1;
	logic wsel = 1'h0;
	logic osel = 1'h0;
	logic mrw_v, mrr_v, dq_oe, rd_v, rng, rsv;
	logic [5:0] addr, code;
	logic [7:0] op, dq;
	logic [9:0] r;
	int mismatches = 0;
	int tests_run = 0;
	always #12.5 core_clk = ~core_clk;
	carl_reg dut (.core_clk_i(core_clk), .rst_i(rst), .mrw_valid_i(mrw_v),
		.mrr_valid_i(mrr_v), .mode_addr_i(addr), .mode_op_i(op),
		.setpoint_write_select_i(wsel), .setpoint_operate_select_i(osel),
		.dq_o(dq), .dq_oe_o(dq_oe), .mrr_data_valid_o(rd_v),
		.ca_ref_level_code_o(code), .ca_ref_range_select_o(rng),
		.ca_ref_code_reserved_o(rsv));
	carl_ctrl_model ctrl (.core_clk_i(core_clk), .dq_i(dq), .dq_oe_i(dq_oe),
		.mrr_data_valid_i(rd_v), .mrw_valid_o(mrw_v), .mrr_valid_o(mrr_v),
		.mode_addr_o(addr), .mode_op_o(op));
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		if (mismatches == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic wr(input logic s, input logic [5:0] a, input logic [7:0] d);
		@(posedge core_clk);
		wsel <= s;
		ctrl.mrw(a, d);
	endtask
	// A read must answer exactly one cycle after the command edge.
	task automatic rd(input logic s, input logic [7:0] e);
		@(posedge core_clk);
		wsel <= s;
		ctrl.mrr(6'h0c, r);
		check(r, {2'h3, e});
	endtask
	task automatic op_chk(input logic [7:0] e);
		repeat (2) @(posedge core_clk);
		#1;
		check({2'h0, rsv, rng, code}, {2'h0, e});
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 1'h0;
		op_chk(8'h5d);
		rd(1'h0, 8'h5d);
		rd(1'h1, 8'h5d);
		wr(1'h0, 6'h0c, 8'hd2);
		rd(1'h0, 8'h52);
		op_chk(8'h52);
		wr(1'h1, 6'h0c, 8'h32);
		op_chk(8'h52);
		rd(1'h1, 8'h32);
		rd(1'h0, 8'h52);
		@(posedge core_clk);
		osel <= 1'h1;
		op_chk(8'h32);
		wr(1'h1, 6'h0d, 8'h05);
		rd(1'h1, 8'h32);
		ctrl.mrr(6'h0d, r);
		check(r, 10'h000);
		wr(1'h1, 6'h0c, 8'h33);
		op_chk(8'hb3);
		@(posedge core_clk);
		rst <= 1'h1;
		@(posedge core_clk);
		rst <= 1'h0;
		op_chk(8'h5d);
		rd(1'h1, 8'h5d);
		end_sim;
	end
	initial begin
		#1000000;
		mismatches++;
		end_sim;
	end
endmodule
